// [include/cwol_pkg.sv]
// package of constants for the watchdog and option latch block
package cwol_pkg;
    // register port geometry
    localparam int         ADDR_W            = 16;
    localparam int         DATA_W            = 8;
    // register byte addresses
    localparam logic [15:0] ADDR_OPTION_ONE  = 16'h001E;
    localparam logic [15:0] ADDR_OPTION_TWO  = 16'h001F;
    localparam logic [15:0] ADDR_WDOG_CLEAR  = 16'hFFFF;
    // reset value of both option latches
    localparam logic [7:0]  OPTION_RESET     = 8'h00;
    // read value for unmapped addresses
    localparam logic [7:0]  UNMAPPED_READ    = 8'h00;
    // low byte of the reset vector; value is arbitrary
    localparam logic [7:0]  RESET_VECTOR_LO  = 8'h5A;
    // option_latch_one field positions
    localparam int          O1_WDOG_DISABLE  = 0;
    localparam int          O1_STOP_ENABLE   = 1;
    localparam int          O1_SHORT_RECOVER = 2;
    localparam int          O1_LVM_OFF       = 3;
    localparam int          O1_TRIP_LEVEL    = 4;
    localparam int          O1_SHORT_TIMEOUT = 5;
    // option_latch_two field positions
    localparam int          O2_OSC_IN_STOP   = 0;
    localparam int          O2_TB_SRC        = 1;
    localparam int          O2_TB_PRESCALE   = 2;
    localparam int          O2_CLKOUT_EN     = 3;
    localparam int          O2_CLKOUT_XTAL   = 4;
    localparam int          O2_CLKOUT_DIV_LO = 5;
    localparam int          O2_CLKOUT_DIV_HI = 6;
    // clock-out divide codes
    localparam logic [1:0]  DIV_BY_1         = 2'h0;
    localparam logic [1:0]  DIV_BY_2         = 2'h1;
    // watchdog timeouts in crystal-derived clock cycles
    localparam int          WDOG_LONG_CYC    = 262128;
    localparam int          WDOG_SHORT_CYC   = 8176;
    localparam int          WDOG_CNT_W       = 18;
    // stop recovery delays in crystal-derived clock cycles
    localparam int          RECOVER_SHORT_CYC = 32;
    localparam int          RECOVER_LONG_CYC  = 4096;
    localparam int          RECOVER_CNT_W     = 13;
    // timebase extra prescaler
    localparam int          TB_PRESCALE      = 128;
    localparam int          TB_CNT_W         = 7;
    // clock-out half period counter width; must hold 8, the bus /4 half period
    localparam int          CLKOUT_CNT_W     = 4;
    // low-power mode states, gray coded along run-wait and stop-recover-run; run to stop flips both bits
    typedef enum logic [1:0] {
        CWOL_RUN     = 2'h0,
        CWOL_WAIT    = 2'h1,
        CWOL_STOP    = 2'h3,
        CWOL_RECOVER = 2'h2
    } cwol_mode_t;
endpackage : cwol_pkg

// [src/cwol_watchdog_option_latches.sv]
// watchdog with write-once option latches and low-power clock gating
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module cwol_watchdog_option_latches
    import cwol_pkg::*;
#(
    parameter int WDOG_LONG  = WDOG_LONG_CYC,   // long watchdog timeout, cycles
    parameter int WDOG_SHORT = WDOG_SHORT_CYC   // short watchdog timeout, cycles
)(
    input  wire logic              core_clk_in,     // crystal-derived clock
    input  wire logic              rst_in,          // system reset, sync, high
    input  wire logic              por_in,          // power-on reset, sync, high
    input  wire logic [ADDR_W-1:0] addr_in,         // register address
    input  wire logic [DATA_W-1:0] wdata_in,        // write data
    input  wire logic              wr_in,           // write strobe
    input  wire logic              rd_in,           // read strobe
    input  wire logic              stop_req_in,     // stop instruction executed
    input  wire logic              wait_req_in,     // wait instruction executed
    input  wire logic              wake_in,         // wake-up event
    output logic [DATA_W-1:0]      rdata_out,       // read data, cycle after strobe
    output logic                   wdog_reset_out,  // one-cycle reset request
    output logic                   cpu_clk_en_out,  // processor clock enable
    output logic                   bus_clk_en_out,  // bus clock enable
    output logic                   lvm_enable_out,  // low-voltage monitor enabled
    output logic                   trip_level_out,  // monitor trip point select
    output logic                   tb_src_out,      // timebase clock source select
    output logic                   tb_tick_out,     // timebase input tick
    output logic                   clkout_out       // clock output pin
);

    // derived counts, cut to the counter width on purpose
    localparam logic [WDOG_CNT_W-1:0]    WDOG_LONG_LAST  = WDOG_CNT_W'(WDOG_LONG - 1);
    localparam logic [WDOG_CNT_W-1:0]    WDOG_SHORT_LAST = WDOG_CNT_W'(WDOG_SHORT - 1);
    localparam logic [RECOVER_CNT_W-1:0] RECOVER_SHORT_LAST =
        RECOVER_CNT_W'(RECOVER_SHORT_CYC - 1);
    localparam logic [RECOVER_CNT_W-1:0] RECOVER_LONG_LAST =
        RECOVER_CNT_W'(RECOVER_LONG_CYC - 1);
    localparam logic [TB_CNT_W-1:0]      TB_LAST      = TB_CNT_W'(TB_PRESCALE - 1);
    localparam logic [CLKOUT_CNT_W-1:0]  CLKOUT_STEP  = CLKOUT_CNT_W'(1);

    logic                     any_reset;        // either reset source
    logic [DATA_W-1:0]        option_one;       // option_latch_one storage
    logic [DATA_W-1:0]        option_two;       // option_latch_two storage
    logic                     trip_level;       // survives non power-on resets
    logic                     one_written;      // option_latch_one locked
    logic                     two_written;      // option_latch_two locked
    logic                     trip_written;     // trip level locked until power-on
    logic [WDOG_CNT_W-1:0]    wdog_cnt;         // watchdog counter
    logic [WDOG_CNT_W-1:0]    wdog_last;        // selected terminal count
    logic                     wdog_clear;       // software clear strike
    logic                     wdog_frozen;      // crystal stopped in stop mode
    cwol_mode_t               mode;             // low-power mode state
    cwol_mode_t               next_mode;        // next low-power mode
    logic [RECOVER_CNT_W-1:0] recover_cnt;      // stop recovery counter
    logic [RECOVER_CNT_W-1:0] recover_last;     // selected recovery count
    logic [TB_CNT_W-1:0]      tb_cnt;           // timebase prescaler
    logic [CLKOUT_CNT_W-1:0]  clkout_cnt;       // clock-out half period counter
    logic [CLKOUT_CNT_W-1:0]  clkout_half;      // selected half period length

    // power-on reset always implies a full reset
    assign any_reset = rst_in | por_in;

    // address match helper shared by the write and read paths
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        hit = (a == b);
    endfunction : hit

    // software clear of the watchdog: any value, any write
    assign wdog_clear = wr_in & hit(addr_in, ADDR_WDOG_CLEAR);

    // option_latch_one: first write after reset takes, later ones are dropped
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            option_one  <= OPTION_RESET;
            one_written <= 1'b0;
        end
        else if (wr_in && hit(addr_in, ADDR_OPTION_ONE) && !one_written)
        begin
            option_one  <= wdata_in;
            one_written <= 1'b1;
        end
    end

    // option_latch_two: same write-once behaviour as the first latch
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            option_two  <= OPTION_RESET;
            two_written <= 1'b0;
        end
        else if (wr_in && hit(addr_in, ADDR_OPTION_TWO) && !two_written)
        begin
            option_two  <= wdata_in;
            two_written <= 1'b1;
        end
    end

    // trip level: only power-on reopens it, so a watchdog reset keeps the level
    always_ff @(posedge core_clk_in)
    begin
        if (por_in)
        begin
            trip_level   <= 1'b0;
            trip_written <= 1'b0;
        end
        else if (!rst_in && wr_in && hit(addr_in, ADDR_OPTION_ONE) && !one_written
                 && !trip_written)
        begin
            trip_level   <= wdata_in[O1_TRIP_LEVEL];
            trip_written <= 1'b1;
        end
    end

    // read path: data stand in the cycle after the strobe only
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            rdata_out <= UNMAPPED_READ;
        end
        else if (rd_in)
        begin
            if (hit(addr_in, ADDR_OPTION_ONE))
            begin
                // trip level is held apart, merge it back into its bit
                rdata_out <= {option_one[7:O1_TRIP_LEVEL+1], trip_level,
                              option_one[O1_TRIP_LEVEL-1:0]};
            end
            else if (hit(addr_in, ADDR_OPTION_TWO))
            begin
                rdata_out <= option_two;
            end
            else if (hit(addr_in, ADDR_WDOG_CLEAR))
            begin
                rdata_out <= RESET_VECTOR_LO;
            end
            else
            begin
                rdata_out <= UNMAPPED_READ;                                        // unmapped
            end
        end
        else
        begin
            rdata_out <= UNMAPPED_READ;                                            // idle bus
        end
    end

    // terminal count picked by the short-timeout option
    assign wdog_last = option_one[O1_SHORT_TIMEOUT] ? WDOG_SHORT_LAST
                                                    : WDOG_LONG_LAST;

    // counter halts only when the oscillator is stopped with the part
    assign wdog_frozen = (mode == CWOL_STOP) && !option_two[O2_OSC_IN_STOP];

    // watchdog counter: a clear in the overflow cycle wins and saves the part
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            wdog_cnt <= '0;
        end
        else if (wdog_clear || wdog_cnt >= wdog_last)
        begin
            wdog_cnt <= '0;
        end
        else if (!wdog_frozen)
        begin
            // keeps counting in wait mode since the bus clock runs
            wdog_cnt <= wdog_cnt + 1'b1;
        end
    end

    // overflow raises a one-cycle reset request unless disabled
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            wdog_reset_out <= 1'b0;
        end
        else
        begin
            wdog_reset_out <= !wdog_clear && !wdog_frozen && (wdog_cnt >= wdog_last)
                              && !option_one[O1_WDOG_DISABLE];
        end
    end

    // recovery delay picked by the short-recovery option
    assign recover_last = option_one[O1_SHORT_RECOVER] ? RECOVER_SHORT_LAST
                                                       : RECOVER_LONG_LAST;

    // low-power mode sequencing
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            CWOL_RUN:
            begin
                // stop is honoured only when the option allows it
                if (stop_req_in && option_one[O1_STOP_ENABLE])
                begin
                    next_mode = CWOL_STOP;
                end
                else if (wait_req_in)
                begin
                    next_mode = CWOL_WAIT;
                end
            end
            CWOL_WAIT:
            begin
                if (wake_in)
                begin
                    next_mode = CWOL_RUN;
                end
            end
            CWOL_STOP:
            begin
                if (wake_in)
                begin
                    next_mode = CWOL_RECOVER;
                end
            end
            CWOL_RECOVER:
            begin
                if (recover_cnt >= recover_last)
                begin
                    next_mode = CWOL_RUN;
                end
            end
        endcase
    end

    // mode register
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            mode <= CWOL_RUN;
        end
        else
        begin
            mode <= next_mode;
        end
    end

    // recovery counter runs only while leaving stop
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset || mode != CWOL_RECOVER)
        begin
            recover_cnt <= '0;
        end
        else
        begin
            recover_cnt <= recover_cnt + 1'b1;
        end
    end

    // clock enables follow the next mode so they change with the state
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            cpu_clk_en_out <= 1'b1;
            bus_clk_en_out <= 1'b1;
        end
        else
        begin
            cpu_clk_en_out <= (next_mode == CWOL_RUN);
            // the recovery window keeps the bus gated until the oscillator settles
            bus_clk_en_out <= !((next_mode == CWOL_STOP || next_mode == CWOL_RECOVER)
                                && !option_two[O2_OSC_IN_STOP]);
        end
    end

    // low-voltage monitor and timebase source straps
    always_ff @(posedge core_clk_in)
    begin
        if (por_in)
        begin
            lvm_enable_out <= 1'b1;
            trip_level_out <= 1'b0;
            tb_src_out     <= 1'b0;
        end
        else
        begin
            lvm_enable_out <= !option_one[O1_LVM_OFF];
            trip_level_out <= trip_level;
            tb_src_out     <= option_two[O2_TB_SRC];
        end
    end

    // timebase tick, optionally divided by the extra prescaler
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset)
        begin
            tb_cnt      <= '0;
            tb_tick_out <= 1'b0;
        end
        else if (option_two[O2_TB_PRESCALE])
        begin
            tb_cnt      <= (tb_cnt == TB_LAST) ? '0 : tb_cnt + 1'b1;
            tb_tick_out <= (tb_cnt == TB_LAST);
        end
        else
        begin
            tb_cnt      <= '0;
            tb_tick_out <= 1'b1;
        end
    end

    // half period: crystal source 1/2/4 cycles, bus source twice that
    always_comb
    begin
        unique case (option_two[O2_CLKOUT_DIV_HI:O2_CLKOUT_DIV_LO])
            DIV_BY_1: clkout_half = CLKOUT_STEP;
            DIV_BY_2: clkout_half = CLKOUT_STEP << 1;
            default:  clkout_half = CLKOUT_STEP << 2;                              // code 3 as 4
        endcase
        if (!option_two[O2_CLKOUT_XTAL])
        begin
            clkout_half = clkout_half << 1;
        end
    end

    // clock output pin: parked low while disabled, so no runt pulse on enable
    always_ff @(posedge core_clk_in)
    begin
        if (any_reset || !option_two[O2_CLKOUT_EN])
        begin
            clkout_cnt <= '0;
            clkout_out <= 1'b0;
        end
        else if (clkout_cnt + CLKOUT_STEP >= clkout_half)
        begin
            clkout_cnt <= '0;
            clkout_out <= !clkout_out;
        end
        else
        begin
            clkout_cnt <= clkout_cnt + CLKOUT_STEP;
        end
    end

endmodule : cwol_watchdog_option_latches
`default_nettype wire

// [testbench/cwol_chk.sv]
// checker watching the ports of the watchdog and option latch block
`timescale 1ns/1ps
`default_nettype none
module cwol_chk
    import cwol_pkg::*;
#(
    parameter int WDOG_LONG  = WDOG_LONG_CYC,   // long timeout, as handed to the design
    parameter int WDOG_SHORT = WDOG_SHORT_CYC   // short timeout, as handed to the design
)(
    input wire logic              core_clk_in,
    input wire logic              rst_in,
    input wire logic              por_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic              stop_req_in,
    input wire logic              wait_req_in,
    input wire logic              wake_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic              wdog_reset_out,
    input wire logic              cpu_clk_en_out,
    input wire logic              bus_clk_en_out,
    input wire logic              lvm_enable_out,
    input wire logic              trip_level_out,
    input wire logic              tb_src_out,
    input wire logic              tb_tick_out,
    input wire logic              clkout_out
);
    logic [7:0] opt1;    // mirror of option_one, trip bit not tracked
    logic [7:0] opt2;    // mirror of option_two
    logic       done1;   // option_one taken since reset
    logic       done2;   // option_two taken since reset
    logic [1:0] up_cnt;  // edges since reset, saturating; masks reset leftovers

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in || por_in);

    // mirror keeps only the first write after each reset
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || por_in)
        begin
            opt1  <= 8'h00;
            opt2  <= 8'h00;
            done1 <= 1'b0;
            done2 <= 1'b0;
        end
        else if (wr_in && addr_in == ADDR_OPTION_ONE && !done1)
        begin
            opt1  <= wdata_in;
            done1 <= 1'b1;
        end
        else if (wr_in && addr_in == ADDR_OPTION_TWO && !done2)
        begin
            opt2  <= wdata_in;
            done2 <= 1'b1;
        end
    end

    // registered outputs settle a couple of edges after reset
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || por_in)
            up_cnt <= 2'h0;
        else if (up_cnt != 2'h3)
            up_cnt <= up_cnt + 2'h1;
    end

    sequence s_stop_wake;
        !cpu_clk_en_out && !bus_clk_en_out && wake_in && opt1[O1_SHORT_RECOVER];
    endsequence
    sequence s_recover;
        !cpu_clk_en_out [*8] ##[22:26] cpu_clk_en_out;
    endsequence

    rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside read slot");
    vector_read_a: assert property (rd_in && addr_in == ADDR_WDOG_CLEAR |=>
        rdata_out == RESET_VECTOR_LO) else $error("clear port read wrong");
    latch_read_a: assert property (rd_in && addr_in == ADDR_OPTION_TWO |=>
        rdata_out == opt2) else $error("option two read wrong");
    clear_quiet_a: assert property (wr_in && addr_in == ADDR_WDOG_CLEAR |=>
        !wdog_reset_out [*8]) else $error("reset soon after clear");
    pulse_gap_a: assert property (wdog_reset_out |=> !wdog_reset_out [*8])
        else $error("watchdog pulses too close");
    disabled_quiet_a: assert property (opt1[O1_WDOG_DISABLE] &&
        $past(opt1[O1_WDOG_DISABLE]) |-> !wdog_reset_out) else $error("disabled reset");
    stop_entry_a: assert property (cpu_clk_en_out && stop_req_in &&
        opt1[O1_STOP_ENABLE] |=> !cpu_clk_en_out && bus_clk_en_out == opt2[O2_OSC_IN_STOP])
        else $error("stop clock gating wrong");
    wait_entry_a: assert property (cpu_clk_en_out && wait_req_in &&
        !(stop_req_in && opt1[O1_STOP_ENABLE]) |=> !cpu_clk_en_out && bus_clk_en_out)
        else $error("wait clock gating wrong");
    recover_a: assert property (s_stop_wake |=> s_recover)
        else $error("short recovery length wrong");
    lvm_follow_a: assert property (up_cnt == 2'h3 |->
        lvm_enable_out == !$past(opt1[O1_LVM_OFF])) else $error("monitor enable wrong");
    tb_src_a: assert property (up_cnt == 2'h3 |->
        tb_src_out == $past(opt2[O2_TB_SRC])) else $error("timebase source wrong");
    tick_gap_a: assert property (opt2[O2_TB_PRESCALE] && $past(opt2[O2_TB_PRESCALE])
        && tb_tick_out |=> !tb_tick_out [*8]) else $error("prescaled tick too close");
    clk_off_a: assert property (!opt2[O2_CLKOUT_EN] && !$past(opt2[O2_CLKOUT_EN])
        && up_cnt == 2'h3 |-> !clkout_out) else $error("clock out not idle");
endmodule : cwol_chk
`default_nettype wire

// [testbench/tb.sv]
// self-checking testbench for the watchdog and option latch block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cwol_pkg::*;
    localparam int LONG_T  = 40;   // shortened long timeout keeps the run brief
    localparam int SHORT_T = 12;   // shortened short timeout
    logic        core_clk_in, rst_in, por_in, wr_in, rd_in;
    logic        stop_req_in, wait_req_in, wake_in;
    logic [15:0] addr_in;
    logic [7:0]  wdata_in, rdata_out, v1, v2;
    logic        wdog_reset_out, cpu_clk_en_out, bus_clk_en_out, lvm_enable_out;
    logic        trip_level_out, tb_src_out, tb_tick_out, clkout_out;
    logic        trip_m, lock_m;   // model of the power-on trip level and its lock
    int          mismatches, checks_done, pulses, p0, k;

    cwol_watchdog_option_latches #(.WDOG_LONG(LONG_T), .WDOG_SHORT(SHORT_T))
        i_cwol_watchdog_option_latches (.core_clk_in, .rst_in, .por_in, .addr_in,
        .wdata_in, .wr_in, .rd_in, .stop_req_in, .wait_req_in, .wake_in, .rdata_out,
        .wdog_reset_out, .cpu_clk_en_out, .bus_clk_en_out, .lvm_enable_out,
        .trip_level_out, .tb_src_out, .tb_tick_out, .clkout_out);

    // free-running 50 MHz clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    // counts watchdog pulses seen
    always @(posedge core_clk_in)
        if (wdog_reset_out === 1'b1)
            pulses++;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // reset held three cycles; power-on also unlocks the trip level
    task automatic do_reset(input logic p);
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        por_in <= p;
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        por_in <= 1'b0;
        if (p)
        begin
            trip_m = 1'b0;
            lock_m = 1'b0;
        end
    endtask : do_reset

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 check({8'h00, rdata_out}, {8'h00, exp});
    endtask : rd

    // first option_one write after power-on also fixes the trip level
    task automatic wr_opt1(input logic [7:0] d);
        wr(ADDR_OPTION_ONE, d);
        if (!lock_m)
        begin
            trip_m = d[4];
            lock_m = 1'b1;
        end
    endtask : wr_opt1

    function automatic logic [7:0] exp1(input logic [7:0] d);
        return {d[7:5], trip_m, d[3:0]};
    endfunction : exp1

    // pulses one input for a single cycle
    task automatic pulse(input int sel);
        @(posedge core_clk_in);
        stop_req_in <= (sel == 0);
        wait_req_in <= (sel == 1);
        wake_in     <= (sel == 2);
        @(posedge core_clk_in);
        {stop_req_in, wait_req_in, wake_in} <= 3'b000;
        #1;
    endtask : pulse

    // edges until pulse, cpu enable, tick, or clock-out change
    task automatic count_until(input int sel, output int n);
        logic s;
        s = clkout_out;
        n = 0;
        do
        begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        while (n < 5000 && !(sel == 0 ? wdog_reset_out === 1'b1 :
               sel == 1 ? cpu_clk_en_out === 1'b1 :
               sel == 2 ? tb_tick_out === 1'b1 : clkout_out !== s));
    endtask : count_until

    // hang guard, well beyond the expected run length
    initial
    begin
        #600000;
        mismatches++;
        results();
    end

    initial
    begin
        {rst_in, por_in, wr_in, rd_in} = 4'hC;
        {stop_req_in, wait_req_in, wake_in} = 3'b000;
        addr_in  = 16'h0000;
        wdata_in = 8'h00;
        void'($urandom(15));
        // latch write-once, reset clearing and trip lock
        for (int i = 0; i < 4; i++)
        begin
            do_reset(i == 0 || i == 3);
            rd(ADDR_OPTION_ONE, exp1(8'h00));
            rd(ADDR_OPTION_TWO, OPTION_RESET);
            rd(ADDR_WDOG_CLEAR, RESET_VECTOR_LO);
            rd(16'h0020, UNMAPPED_READ);
            check({cpu_clk_en_out, bus_clk_en_out}, 16'h0003);
            v1 = 8'($urandom);
            v2 = 8'($urandom);
            wr_opt1(v1);
            wr(ADDR_OPTION_TWO, v2);
            rd(ADDR_OPTION_ONE, exp1(v1));
            wr_opt1(~v1);
            wr(ADDR_OPTION_TWO, ~v2);
            rd(ADDR_OPTION_ONE, exp1(v1));
            rd(ADDR_OPTION_TWO, v2);
            check({lvm_enable_out, trip_level_out}, {~v1[3], trip_m});
            $display("latch test %0d done", i);
        end
        // watchdog timeout lengths, periodic clearing, disable
        for (int s = 0; s < 2; s++)
        begin
            do_reset(1'b0);
            wr_opt1(s ? 8'h20 : 8'h00);
            wr(ADDR_WDOG_CLEAR, 8'($urandom));
            count_until(0, k);
            check(16'(k), 16'(s ? SHORT_T : LONG_T));
        end
        wr(ADDR_WDOG_CLEAR, 8'($urandom));
        p0 = pulses;
        repeat (6)
        begin
            repeat (SHORT_T - 4) @(posedge core_clk_in);
            wr(ADDR_WDOG_CLEAR, 8'($urandom));
        end
        check(16'(pulses - p0), 16'h0000);
        do_reset(1'b0);
        wr_opt1(8'h21);
        p0 = pulses;
        repeat (3 * LONG_T) @(posedge core_clk_in);
        check(16'(pulses - p0), 16'h0000);
        // stop request with the stop option clear must leave both clocks running
        pulse(0);
        check({cpu_clk_en_out, bus_clk_en_out}, 16'h0003);
        $display("watchdog test done");
        // stop with both recovery lengths and oscillator settings, then wait
        for (int i = 0; i < 2; i++)
        begin
            do_reset(1'b0);
            wr_opt1(i ? 8'h03 : 8'h07);
            wr(ADDR_OPTION_TWO, {7'h00, i[0]});
            pulse(0);
            check({cpu_clk_en_out, bus_clk_en_out}, {15'h0000, i[0]});
            pulse(2);
            count_until(1, k);
            check(16'(k), 16'(i ? RECOVER_LONG_CYC : RECOVER_SHORT_CYC));
            pulse(1);
            check({cpu_clk_en_out, bus_clk_en_out}, 16'h0001);
            pulse(2);
            check({15'h0000, cpu_clk_en_out}, 16'h0001);
            $display("low power test %0d done", i);
        end
        // prescaled timebase tick and clock-out divide for each source and code
        for (int c = 0; c < 8; c++)
        begin
            do_reset(1'b0);
            wr(ADDR_OPTION_TWO, {1'b0, c[1:0], c[2], 2'b11, 1'($urandom), 1'b0});
            count_until(2, k);
            count_until(2, k);
            check(16'(k), 16'(TB_PRESCALE));
            count_until(3, k);
            count_until(3, k);
            check(16'(k), 16'((c[1] ? 4 : c[0] ? 2 : 1) * (c[2] ? 1 : 2)));
            $display("clock out test %0d done", c);
        end
        results();
    end
endmodule : tb

bind cwol_watchdog_option_latches cwol_chk #(.WDOG_LONG(WDOG_LONG), .WDOG_SHORT(WDOG_SHORT))
    i_cwol_chk (.core_clk_in, .rst_in, .por_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .stop_req_in, .wait_req_in, .wake_in, .rdata_out, .wdog_reset_out, .cpu_clk_en_out,
    .bus_clk_en_out, .lvm_enable_out, .trip_level_out, .tb_src_out, .tb_tick_out,
    .clkout_out);
`default_nettype wire
